// ===== bench/tb_top.sv
/*
  Self-checking bench for the timer block over its Avalon-MM slave.
  Assumes one 50 MHz clock and the package's register indices.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import timer8_pkg::*;
;
  logic        clk, rstn, read, write, waitrequest, p0;
  logic [31:0] address, writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [1:0]  event_input_pin, count_ext_tick, timer_output_pin, match_interrupt;
  int          fail_count, comparisons, cycles, n, hi, irqs;

  timer8_mode_control_ops i_dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .event_input_pin(event_input_pin),
    .count_ext_tick(count_ext_tick), .timer_output_pin(timer_output_pin),
    .match_interrupt(match_interrupt));

  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (match_interrupt[0] === 1'b1) irqs++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a; writedata <= d; write <= wr_en; read <= !wr_en;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata; write <= 1'b0; read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rdchk(input string name, input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    check(name, rd, {24'h0, e});
  endtask : rdchk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_irq();
    n = 0;
    do begin tick(1); n++; end while (match_interrupt[0] !== 1'b1 && n < 1000);
  endtask : wait_irq
  task automatic duty(input int e);
    tick(300);
    hi = 0;
    repeat (512) begin tick(1); hi += int'(timer_output_pin[0] === 1'b1); end
    check("pwm high cycles", hi, e);
  endtask : duty

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  logic [7:0] nv [2] = '{8'h03, 8'hFF};
  initial begin
    rstn = 1'b0; read = 1'b0; write = 1'b0; address = 32'h0; writedata = 32'h0;
    byteenable = 4'hF; event_input_pin = 2'h0; count_ext_tick = 2'h0;
    fail_count = 0; comparisons = 0; cycles = 0; irqs = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdchk("mode0 reset", IDX_MODE_CONTROL_0, 8'h00);
    rdchk("mode1 reset", IDX_MODE_CONTROL_1, 8'h00);
    rdchk("unmapped", 32'h0, 8'h00);
    wr(IDX_MODE_CONTROL_1, 8'h12);
    rdchk("mode1 chain", IDX_MODE_CONTROL_1, 8'h12);
    wr(IDX_MODE_CONTROL_1, 8'h00);
    wr(IDX_MODE_CONTROL_0, 8'h1A);
    rdchk("mode0 bits", IDX_MODE_CONTROL_0, 8'h02);
    tick(2); check("pin disabled", 32'(timer_output_pin[0]), 32'h0);
    wr(IDX_MODE_CONTROL_0, 8'h03);
    tick(2); check("pin set", 32'(timer_output_pin[0]), 32'h1);
    wr(IDX_MODE_CONTROL_0, 8'h07);
    tick(2); check("pin cleared", 32'(timer_output_pin[0]), 32'h0);
    wr(IDX_CLOCK_SELECT_0, {5'h0, CLK_DIV1});
    foreach (nv[i]) begin
      wr(IDX_COMPARE_0, nv[i]); wr(IDX_MODE_CONTROL_0, 8'h0B);
      wr(IDX_MODE_CONTROL_0, 8'h8B);
      wait_irq(); wait_irq(); check("interval", n, 32'(nv[i]) + 1);
      tick(2); p0 = timer_output_pin[0];
      wait_irq(); tick(2); check("toggle", 32'(timer_output_pin[0]), 32'(!p0));
      wr(IDX_MODE_CONTROL_0, 8'h0B); wr(IDX_COUNT_VALUE_0, 8'h55);
      rdchk("stopped count", IDX_COUNT_VALUE_0, 8'h00);
    end
    wr(IDX_COMPARE_0, 8'h02);
    for (int c = 0; c < 2; c++) begin
      event_input_pin[0] <= !c[0];
      wr(IDX_CLOCK_SELECT_0, c[7:0]); wr(IDX_MODE_CONTROL_0, 8'h00);
      wr(IDX_MODE_CONTROL_0, 8'h80);
      tick(4); irqs = 0;
      for (int e = 0; e < 3; e++) begin
        event_input_pin[0] <= c[0]; tick(4); event_input_pin[0] <= !c[0]; tick(4);
        if (e == 1) check("irq before third edge", irqs, 0);
      end
      check("irq after third edge", irqs, 1);
    end
    wr(IDX_CLOCK_SELECT_0, {5'h0, CLK_DIV1}); wr(IDX_COMPARE_0, 8'h02);
    wr(IDX_COMPARE_1, 8'h01); wr(IDX_MODE_CONTROL_1, 8'h10);
    wr(IDX_MODE_CONTROL_1, 8'h90); wr(IDX_MODE_CONTROL_0, 8'h80);
    wait_irq(); wait_irq(); check("cascade interval", n, 32'h103);
    wr(IDX_MODE_CONTROL_0, 8'h00); wr(IDX_MODE_CONTROL_1, 8'h09);
    tick(2); check("pin1 set", 32'(timer_output_pin[1]), 32'h1);
    wr(IDX_MODE_CONTROL_1, 8'h00);
    wr(IDX_CLOCK_SELECT_0, {5'h0, CLK_DIV1}); wr(IDX_COMPARE_0, 8'h40);
    wr(IDX_MODE_CONTROL_0, 8'h0B); wr(IDX_MODE_CONTROL_0, 8'h41);
    wr(IDX_MODE_CONTROL_0, 8'h45); wr(IDX_MODE_CONTROL_0, 8'hC1);
    duty(128);
    wr(IDX_MODE_CONTROL_0, 8'hC3);
    duty(384);
    wr(IDX_MODE_CONTROL_0, 8'h43); wr(IDX_MODE_CONTROL_0, 8'h03);
    tick(2); check("pin after pwm", 32'(timer_output_pin[0]), 32'h1);
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire

// ===== bench/timer8_mode_control_ops_sva.sv
/*
  Port-level checks of the timer block: bus answer timing, mode read-back,
  output gating and interrupt pulses of channel 0.
  Assumes one clock, word addresses equal to register indices.
*/
`timescale 1ns/1ps
`default_nettype none

module timer8_mode_control_ops_sva
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // avalon-mm slave
  input wire logic [31:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // board side and interrupts
  input wire logic [1:0]  timer_output_pin,
  input wire logic [1:0]  match_interrupt
);
  // ----------------------------------------
  // mode shadow
  // ----------------------------------------
  logic [7:0] mode_shadow;
  logic       rd_done;
  assign rd_done = read && !waitrequest;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mode_shadow <= 8'h00;
    else if (write && !waitrequest && byteenable[0] && address == IDX_MODE_CONTROL_0)
      mode_shadow <= writedata[7:0] & MODE_STORE_MASK;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_irq_pulse; match_interrupt[0] |=> !match_interrupt[0]; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_ff_zero; rd_done && address[31:1] == IDX_MODE_CONTROL_0[31:1]
    |-> readdata[3:2] == 2'h0; endproperty
  a_ff_zero: assert property (p_ff_zero) else $error("set clear read nonzero");
  property p_chain0; rd_done && address == IDX_MODE_CONTROL_0 |-> !readdata[BIT_CHAIN];
  endproperty
  a_chain0: assert property (p_chain0) else $error("chain bit of unit 0 set");
  property p_out_off; !mode_shadow[BIT_OUT_EN] && !$past(mode_shadow[BIT_OUT_EN])
    |-> !timer_output_pin[0]; endproperty
  a_out_off: assert property (p_out_off) else $error("pin high while disabled");
  property p_pwm_idle; mode_shadow[BIT_PWM] && !mode_shadow[BIT_RUN]
    && mode_shadow[BIT_OUT_EN] && $stable(mode_shadow)
    && mode_shadow == $past(mode_shadow, 2)
    |-> timer_output_pin[0] == mode_shadow[BIT_INV_POL]; endproperty
  a_pwm_idle: assert property (p_pwm_idle) else $error("pwm not inactive");
  property p_stop_count; rd_done && address == IDX_COUNT_VALUE_0 && !mode_shadow[BIT_RUN]
    && !$past(mode_shadow[BIT_RUN]) && !$past(mode_shadow[BIT_RUN], 2)
    |-> readdata == 32'h0; endproperty
  a_stop_count: assert property (p_stop_count) else $error("stopped count nonzero");
  property p_irq_run; match_interrupt[0] |-> $past(mode_shadow[BIT_RUN]); endproperty
  a_irq_run: assert property (p_irq_run) else $error("irq while stopped");
endmodule : timer8_mode_control_ops_sva

bind timer8_mode_control_ops timer8_mode_control_ops_sva i_sva (.clk(clk), .rstn(rstn),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .timer_output_pin(timer_output_pin), .match_interrupt(match_interrupt));

`default_nettype wire

// ===== verilog/timer8_mode_control_ops.sv
/*
  Two 8-bit timer/event counters with mode control, compare, clock select
  and a 16-bit cascade of channel 1 onto channel 0, behind an Avalon-MM
  slave with waitrequest. Assumes one clock, inputs synchronous to it,
  word addressing (address equals register index), data in bits 7:0.
*/
// Behaviour
// - run bit low clears and holds counter; high lets it count
// - pwm_select_bit 0 gives clear-on-match, 1 gives free-running PWM
// - chain_select_bit 1 chains channel 1 onto channel 0 as 16 bits
// - chain_select_bit of channel 0 is fixed at zero
// - set/clear pair 00 keeps, 01 clears, 10 sets; 11 never written
// - set/clear pair ignored while PWM mode is selected
// - set and clear bits always read back as zero
// - bit 1 enables toggle on match, or picks PWM active level
// - output enable low drives pin low, high drives output state
// - mode and output bits reach the pin even while stopped
// - PWM output forced inactive while run bit is zero
// - mode control register byte and bit access, resets to zero
// - interval match clears counter, keeps counting, raises interrupt
// - interval match repeats every N+1 count clocks, N 00 to FF
// - event mode counts selected edge; code 0 falling, 1 rising
// - event mode match after N+1 valid edges, counter reset
// - square wave toggles output on each match, clears, interrupts
// - PWM width from compare, polarity bit, enable gates pin
// - counter steps on each count clock tick and is read-only
// - PWM active on overflow, inactive at match, period 256
// - cascade compares full 16 bits, match only on full equality
`timescale 1ns/1ps
`default_nettype none

module timer8_mode_control_ops
  import timer8_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // board side
  input  wire logic [1:0]        event_input_pin,
  input  wire logic [1:0]        count_ext_tick,
  output logic      [1:0]        timer_output_pin,
  // interrupt requests
  output logic      [1:0]        match_interrupt
);

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  if (ADDR_W != 32) begin : g_addr_check
    $error("ADDR_W must be 32");
  end
  if (MODE_STORE_MASK[BIT_FF_SET] || MODE_STORE_MASK[BIT_FF_CLEAR]) begin : g_pair_check
    $error("set/clear bits must not be stored");
  end
  if (!MODE_STORE_MASK[BIT_CHAIN] || !MODE_STORE_MASK[BIT_RUN]) begin : g_mask_check
    $error("run and chain bits must be stored");
  end
  if (MODE_RESET != 8'h00) begin : g_reset_check
    $error("mode control must reset to zero");
  end
  if (COUNT_FULL != 8'hFF) begin : g_full_check
    $error("count must wrap after 256 clocks");
  end
  if (FF_KEEP != 2'h0 || FF_CLEAR == FF_SET) begin : g_code_check
    $error("set/clear codes are malformed");
  end
  if (COMPARE_RESET != 8'h00 || CLOCK_SEL_RESET != 3'h0) begin : g_zero_check
    $error("compare and clock select must reset to zero");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] mode;
    logic [1:0][2:0] clk_sel;
    logic [1:0][7:0] compare;
    logic [1:0][7:0] pwm_compare;
    logic [1:0][7:0] count;
    logic [1:0]      out_ff;
    logic [1:0]      pwm_active;
    logic [1:0]      ev_prev;
    logic [7:0]      prescale;
    logic [1:0]      irq;
    logic [1:0]      pin;
    logic [31:0]     rdata;
    logic            wait_req;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // --------------------------------------------------------------
  // register helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] mode_index(input int ch);
    return (ch == 0) ? IDX_MODE_CONTROL_0 : IDX_MODE_CONTROL_1;
  endfunction : mode_index

  function automatic logic [31:0] clock_index(input int ch);
    return (ch == 0) ? IDX_CLOCK_SELECT_0 : IDX_CLOCK_SELECT_1;
  endfunction : clock_index

  function automatic logic [31:0] compare_index(input int ch);
    return (ch == 0) ? IDX_COMPARE_0 : IDX_COMPARE_1;
  endfunction : compare_index

  function automatic logic [7:0] mode_store(input int ch, input logic [7:0] d);
    logic [7:0] v;
    v = d & MODE_STORE_MASK;
    if (ch == 0) begin
      v[BIT_CHAIN] = 1'b0;
    end
    return v;
  endfunction : mode_store

  function automatic logic apply_pair(input logic cur, input logic [1:0] code);
    logic v;
    v = cur;
    unique case (code)
      FF_CLEAR: v = 1'b0;
      FF_SET:   v = 1'b1;
      default:  v = cur;
    endcase
    return v;
  endfunction : apply_pair

  function automatic logic [7:0] read_mux(input state_s s, input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      IDX_MODE_CONTROL_0: v = s.mode[0];
      IDX_MODE_CONTROL_1: v = s.mode[1];
      IDX_CLOCK_SELECT_0: v = {5'h00, s.clk_sel[0]};
      IDX_CLOCK_SELECT_1: v = {5'h00, s.clk_sel[1]};
      IDX_COUNT_VALUE_0:  v = s.count[0];
      IDX_COUNT_VALUE_1:  v = s.count[1];
      IDX_COMPARE_0:      v = s.compare[0];
      IDX_COMPARE_1:      v = s.compare[1];
      default:            v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  // --------------------------------------------------------------
  // count clock selection
  // --------------------------------------------------------------
  function automatic logic sel_tick(input logic [2:0] sel, input logic rise,
                                    input logic fall, input logic [7:0] pre,
                                    input logic ext);
    logic t;
    t = 1'b0;
    unique case (sel)
      CLK_EV_FALL:  t = fall;
      CLK_EV_RISE:  t = rise;
      CLK_DIV1:     t = 1'b1;
      CLK_DIV2:     t = pre[0];
      CLK_DIV4:     t = &pre[1:0];
      CLK_DIV64:    t = &pre[5:0];
      CLK_DIV256:   t = &pre;
      CLK_EXT_TICK: t = ext;
    endcase
    return t;
  endfunction : sel_tick

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  logic [1:0]  tick;
  logic        cascade;
  logic        bus_go;
  logic [15:0] wide_count;
  logic [15:0] wide_compare;
  logic [7:0]  mode_w;
  logic [7:0]  rd8;
  logic [7:0]  cnt_inc;
  logic [1:0]  ev_rise;
  logic [1:0]  ev_fall;
  logic [1:0]  run_on;
  logic [1:0]  pwm_on;

  always_comb begin
    state_next          = state_reg;
    state_next.irq      = 2'h0;
    state_next.wait_req = 1'b1;
    state_next.prescale = state_reg.prescale + 8'h01;
    state_next.ev_prev  = event_input_pin;
    cascade             = state_reg.mode[1][BIT_CHAIN];
    wide_count          = {state_reg.count[1], state_reg.count[0]};
    wide_compare        = {state_reg.compare[1], state_reg.compare[0]};
    bus_go              = 1'b0;
    mode_w              = 8'h00;
    rd8                 = 8'h00;
    cnt_inc             = 8'h00;

    // --------------------------------------------------------------
    // event edges, count clock and mode decode per channel
    // --------------------------------------------------------------
    ev_rise             = event_input_pin & ~state_reg.ev_prev;
    ev_fall             = ~event_input_pin & state_reg.ev_prev;
    for (int i = 0; i < 2; i++) begin
      tick[i]   = sel_tick(state_reg.clk_sel[i], ev_rise[i], ev_fall[i],
                           state_reg.prescale, count_ext_tick[i]);
      run_on[i] = state_reg.mode[i][BIT_RUN];
      pwm_on[i] = state_reg.mode[i][BIT_PWM];
    end

    // --------------------------------------------------------------
    // per-channel counting
    // --------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      cnt_inc = state_reg.count[i] + 8'h01;
      if (!run_on[i]) begin
        state_next.count[i]      = 8'h00;
        state_next.pwm_active[i] = 1'b0;
      end else if (tick[i]) begin
        if (pwm_on[i]) begin
          state_next.count[i] = cnt_inc;
          if (state_reg.count[i] == COUNT_FULL) begin
            state_next.pwm_compare[i] = state_reg.compare[i];
            state_next.pwm_active[i]  = (state_reg.compare[i] != 8'h00);
          end else if (cnt_inc == state_reg.pwm_compare[i]) begin
            state_next.pwm_active[i] = 1'b0;
            state_next.irq[i]        = 1'b1;
          end
        end else if (state_reg.count[i] == state_reg.compare[i]) begin
          state_next.count[i] = 8'h00;
          state_next.irq[i]   = 1'b1;
          if (state_reg.mode[i][BIT_INV_POL]) begin
            state_next.out_ff[i] = ~state_reg.out_ff[i];
          end
        end else begin
          state_next.count[i] = cnt_inc;
        end
      end
    end

    // --------------------------------------------------------------
    // cascade: channel 0 clock and run steer the 16-bit pair
    // --------------------------------------------------------------
    if (cascade) begin
      state_next.irq       = 2'h0;
      state_next.out_ff[0] = state_reg.out_ff[0];
      if (!run_on[0]) begin
        state_next.count[0] = 8'h00;
        state_next.count[1] = 8'h00;
      end else if (tick[0]) begin
        if (wide_count == wide_compare) begin
          state_next.count[0] = 8'h00;
          state_next.count[1] = 8'h00;
          state_next.irq[0]   = 1'b1;
          if (state_reg.mode[0][BIT_INV_POL]) begin
            state_next.out_ff[0] = ~state_reg.out_ff[0];
          end
        end else begin
          {state_next.count[1], state_next.count[0]} = wide_count + 16'h0001;
        end
      end
    end

    // --------------------------------------------------------------
    // bus write, answered one cycle after the request appears
    // --------------------------------------------------------------
    if ((read || write) && state_reg.wait_req) begin
      state_next.wait_req = 1'b0;
    end
    bus_go = write && !state_reg.wait_req && byteenable[0];
    if (bus_go) begin
      for (int i = 0; i < 2; i++) begin
        if (address == mode_index(i)) begin
          mode_w             = mode_store(i, writedata[7:0]);
          state_next.mode[i] = mode_w;
          if (!mode_w[BIT_PWM]) begin
            state_next.out_ff[i] = apply_pair(state_next.out_ff[i],
                                              writedata[BIT_FF_SET:BIT_FF_CLEAR]);
          end
        end
        if (address == clock_index(i)) begin
          state_next.clk_sel[i] = writedata[2:0];
        end
        if (address == compare_index(i)) begin
          state_next.compare[i] = writedata[7:0];
        end
      end
    end

    // --------------------------------------------------------------
    // bus read, data stands while waitrequest is low
    // --------------------------------------------------------------
    if (read && state_reg.wait_req) begin
      rd8              = read_mux(state_reg, address);
      state_next.rdata = {24'h000000, rd8};
    end

    // --------------------------------------------------------------
    // output pin, independent of run except PWM inactive level
    // --------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      if (!state_reg.mode[i][BIT_OUT_EN]) begin
        state_next.pin[i] = 1'b0;
      end else if (state_reg.mode[i][BIT_PWM]) begin
        state_next.pin[i] = state_reg.pwm_active[i] ^ state_reg.mode[i][BIT_INV_POL];
      end else begin
        state_next.pin[i] = state_reg.out_ff[i];
      end
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg             <= '0;
      state_reg.mode        <= {MODE_RESET, MODE_RESET};
      state_reg.clk_sel     <= {CLOCK_SEL_RESET, CLOCK_SEL_RESET};
      state_reg.compare     <= {COMPARE_RESET, COMPARE_RESET};
      state_reg.pwm_compare <= {COMPARE_RESET, COMPARE_RESET};
      state_reg.wait_req    <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign readdata         = state_reg.rdata;
  assign waitrequest      = state_reg.wait_req;
  assign timer_output_pin = state_reg.pin;
  assign match_interrupt  = state_reg.irq;

endmodule : timer8_mode_control_ops

`default_nettype wire

// ===== verilog/timer8_pkg.sv
/*
  Constants for the dual 8-bit timer/event counter: register indices,
  mode control field positions, clock select codes and reset values.
  Assumes a word-addressed Avalon-MM slave where the address is the index.
*/
`default_nettype none

package timer8_pkg;

  // --------------------------------------------------------------
  // register indices (word addresses)
  // --------------------------------------------------------------
  localparam logic [31:0] IDX_CLOCK_SELECT_0 = 32'hFFFFF5C4;
  localparam logic [31:0] IDX_CLOCK_SELECT_1 = 32'hFFFFF5C5;
  localparam logic [31:0] IDX_MODE_CONTROL_0 = 32'hFFFFF5C6;
  localparam logic [31:0] IDX_MODE_CONTROL_1 = 32'hFFFFF5C7;
  localparam logic [31:0] IDX_COUNT_VALUE_0  = 32'hFFFFF5D0;
  localparam logic [31:0] IDX_COUNT_VALUE_1  = 32'hFFFFF5D1;
  localparam logic [31:0] IDX_COMPARE_0      = 32'hFFFFF5D2;
  localparam logic [31:0] IDX_COMPARE_1      = 32'hFFFFF5D3;

  // --------------------------------------------------------------
  // mode control fields
  // --------------------------------------------------------------
  localparam int BIT_RUN      = 7;
  localparam int BIT_PWM      = 6;
  localparam int BIT_CHAIN    = 4;
  localparam int BIT_FF_SET   = 3;
  localparam int BIT_FF_CLEAR = 2;
  localparam int BIT_INV_POL  = 1;
  localparam int BIT_OUT_EN   = 0;

  // bits that are stored; set/clear and bit 5 are not
  localparam logic [7:0] MODE_STORE_MASK  = 8'hD3;
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] COMPARE_RESET    = 8'h00;
  localparam logic [7:0] COUNT_FULL       = 8'hFF;
  localparam logic [2:0] CLOCK_SEL_RESET  = 3'h0;

  // set/clear pair codes
  localparam logic [1:0] FF_KEEP  = 2'h0;
  localparam logic [1:0] FF_CLEAR = 2'h1;
  localparam logic [1:0] FF_SET   = 2'h2;

  // --------------------------------------------------------------
  // count clock select codes
  // --------------------------------------------------------------
  localparam logic [2:0] CLK_EV_FALL  = 3'h0;
  localparam logic [2:0] CLK_EV_RISE  = 3'h1;
  localparam logic [2:0] CLK_DIV1     = 3'h2;
  localparam logic [2:0] CLK_DIV2     = 3'h3;
  localparam logic [2:0] CLK_DIV4     = 3'h4;
  localparam logic [2:0] CLK_DIV64    = 3'h5;
  localparam logic [2:0] CLK_DIV256   = 3'h6;
  localparam logic [2:0] CLK_EXT_TICK = 3'h7;

endpackage : timer8_pkg

`default_nettype wire
